// *** shared/tcm_cfg.svh ***
// Offsets, field positions, reset values and codes of the timer channel block
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

// Register byte offsets, one aligned word each
`define TCM_OFS_TSC   8'h00
`define TCM_OFS_MOD   8'h04
`define TCM_OFS_CNT   8'h08
`define TCM_OFS_CSC   8'h0c
`define TCM_OFS_CVH   8'h10
`define TCM_OFS_CVL   8'h14

// Timer status/control field positions
`define TCM_TSC_CENTER_ALIGNED_PWM  5
`define TCM_TSC_CLKH  4
`define TCM_TSC_CLKL  3

// Channel status/control field positions
`define TCM_CSC_FLAG  7
`define TCM_CSC_IE    6

// Clock select codes
`define TCM_CLK_NONE  2'h0
`define TCM_CLK_BUS   2'h1
`define TCM_CLK_FIX   2'h2
`define TCM_CLK_EXT   2'h3

// Edge/level codes
`define TCM_EL_OFF    2'h0
`define TCM_EL_RISE   2'h1
`define TCM_EL_FALL   2'h2
`define TCM_EL_BOTH   2'h3

// Reset values and counter limits
`define TCM_RST_BYTE  8'h00
`define TCM_RST_WORD  16'h0000
`define TCM_CNT_MAX   16'hffff
`define TCM_ONE       16'h0001

`endif

// *** shared/tcm_pkg.sv ***
// Types shared by the timer channel block
package tcm_pkg;

  typedef enum logic [1:0] {
    TCM_MODE_CAPTURE,
    TCM_MODE_COMPARE,
    TCM_MODE_EDGE_ALIGNED_PWM,
    TCM_MODE_CENTER_ALIGNED_PWM
  } tcm_mode_t;

  typedef struct packed {
    logic       channel_event_flag;
    logic       channel_irq_enable;
    logic       mode_select_high;
    logic       mode_select_low;
    logic       edge_level_high;
    logic       edge_level_low;
    logic [1:0] spare;
  } tcm_csc_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } tcm_bus_t;

  function automatic tcm_mode_t tcm_mode(input logic center_aligned_pwm, input tcm_csc_t c);
    if (center_aligned_pwm) begin
      return TCM_MODE_CENTER_ALIGNED_PWM;
    end else if (c.mode_select_high) begin
      return TCM_MODE_EDGE_ALIGNED_PWM;
    end else if (c.mode_select_low) begin
      return TCM_MODE_COMPARE;
    end
    return TCM_MODE_CAPTURE;
  endfunction

endpackage

// *** hw/tcm_channel_top.sv ***
// Timer counter with one capture/compare/PWM channel behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "tcm_cfg.svh"

module tcm_channel_top
  import tcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // Debug and counter clock sources
  input  wire logic        debug_halt_in,
  input  wire logic        fixed_tick_in,
  input  wire logic        ext_clk_in,
  // Channel pin
  input  wire logic        chan_pin_in,
  output logic             chan_pin_out,
  output logic             chan_pin_oe_out,
  output logic             chan_pin_released_out
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  tcm_bus_t    dph_q;
  logic        rwait_q;
  logic [31:0] hrdata_q;
  logic        acc;
  logic        wr_now;
  logic        rd_now;

  // Reads take one wait state so a write just before is seen
  assign hreadyout_out = ~rwait_q;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_q;
  assign acc    = hsel_in & htrans_in[1] & hready_in;
  assign wr_now = dph_q.valid & dph_q.write & ~rwait_q;
  assign rd_now = rwait_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dph_q   <= '0;
      rwait_q <= 1'b0;
    end else begin
      rwait_q <= hreadyout_out & acc & ~hwrite_in;
      if (hreadyout_out) begin
        dph_q <= '{valid: acc, write: hwrite_in, addr: haddr_in[7:0]};
      end
    end
  end

  logic tsc_wr, mod_wr, cnt_wr, csc_wr, cvh_wr, cvl_wr;
  logic csc_rd, cvh_rd, cvl_rd;
  assign tsc_wr = wr_now & (dph_q.addr == `TCM_OFS_TSC);
  assign mod_wr = wr_now & (dph_q.addr == `TCM_OFS_MOD);
  assign cnt_wr = wr_now & (dph_q.addr == `TCM_OFS_CNT);
  assign csc_wr = wr_now & (dph_q.addr == `TCM_OFS_CSC);
  assign cvh_wr = wr_now & (dph_q.addr == `TCM_OFS_CVH);
  assign cvl_wr = wr_now & (dph_q.addr == `TCM_OFS_CVL);
  assign csc_rd = rd_now & (dph_q.addr == `TCM_OFS_CSC);
  assign cvh_rd = rd_now & (dph_q.addr == `TCM_OFS_CVH);
  assign cvl_rd = rd_now & (dph_q.addr == `TCM_OFS_CVL);

  // ----------------------------------------------------------------
  // Timer control and counter
  // ----------------------------------------------------------------
  logic        center_aligned_pwm_q;
  logic [1:0]  clks_q;
  logic [15:0] mod_q;
  logic [15:0] cnt_q;
  logic        down_q;
  logic        step_q;
  logic        step_up_q;
  logic        ext_prev_q;
  logic        tick;
  logic [15:0] term;
  logic        halted;

  assign halted = debug_halt_in;
  assign term   = (mod_q == `TCM_RST_WORD) ? `TCM_CNT_MAX : mod_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      center_aligned_pwm_q <= 1'b0;
      clks_q <= `TCM_CLK_NONE;
      mod_q  <= `TCM_RST_WORD;
    end else begin
      if (tsc_wr) begin
        center_aligned_pwm_q <= hwdata_in[`TCM_TSC_CENTER_ALIGNED_PWM];
        clks_q <= hwdata_in[`TCM_TSC_CLKH:`TCM_TSC_CLKL];
      end
      if (mod_wr) begin
        mod_q <= hwdata_in[15:0];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clk_in;
    end
  end

  // Counter freezes while halted; no prescaler stage
  always_comb begin
    case (clks_q)
      `TCM_CLK_BUS: tick = ~halted;
      `TCM_CLK_FIX: tick = ~halted & fixed_tick_in;
      `TCM_CLK_EXT: tick = ~halted & ext_clk_in & ~ext_prev_q;
      default:      tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q  <= `TCM_RST_WORD;
      down_q <= 1'b0;
    end else if (cnt_wr) begin
      cnt_q  <= `TCM_RST_WORD;
      down_q <= 1'b0;
    end else if (tick) begin
      if (!center_aligned_pwm_q) begin
        down_q <= 1'b0;
        cnt_q  <= (cnt_q >= term) ? `TCM_RST_WORD : cnt_q + `TCM_ONE;
      end else if (!down_q) begin
        if (cnt_q >= term) begin
          down_q <= 1'b1;
          cnt_q  <= cnt_q - `TCM_ONE;
        end else begin
          cnt_q <= cnt_q + `TCM_ONE;
        end
      end else if (cnt_q == `TCM_RST_WORD) begin
        down_q <= 1'b0;
        cnt_q  <= `TCM_ONE;
      end else begin
        cnt_q <= cnt_q - `TCM_ONE;
      end
    end
  end

  // Marks the cycle after the counter moved, when it shows its new value
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_q    <= 1'b0;
      step_up_q <= 1'b0;
    end else begin
      step_q    <= tick & ~cnt_wr;
      step_up_q <= tick & ~cnt_wr & ~(center_aligned_pwm_q & (down_q | (cnt_q >= term)));
    end
  end

  // ----------------------------------------------------------------
  // Channel mode and events
  // ----------------------------------------------------------------
  tcm_csc_t    csc_q;
  tcm_mode_t   mode;
  logic [1:0]  els;
  logic [15:0] val_q;
  logic        pin_prev_q;
  logic        armed_q;
  logic        is_cap;
  logic        is_pwm;
  logic        match;
  logic        cap_ev;
  logic        cmp_ev;
  logic        ev;
  logic        edge_hit;

  assign mode   = tcm_mode(center_aligned_pwm_q, csc_q);
  assign els    = {csc_q.edge_level_high, csc_q.edge_level_low};
  assign is_cap = (mode == TCM_MODE_CAPTURE);
  assign is_pwm = (mode == TCM_MODE_EDGE_ALIGNED_PWM) | (mode == TCM_MODE_CENTER_ALIGNED_PWM);
  assign match  = step_q & (cnt_q == val_q);

  always_comb begin
    case (els)
      `TCM_EL_RISE: edge_hit = chan_pin_in & ~pin_prev_q;
      `TCM_EL_FALL: edge_hit = ~chan_pin_in & pin_prev_q;
      `TCM_EL_BOTH: edge_hit = chan_pin_in ^ pin_prev_q;
      default:      edge_hit = 1'b0;
    endcase
  end

  // Spurious edge if the pin moved just before capture was chosen
  assign cap_ev = is_cap & edge_hit;
  // No flag for a zero value or a value above the modulo in either PWM mode
  assign cmp_ev = ~is_cap & match & ~(is_pwm & ((val_q == `TCM_RST_WORD) | (val_q > term)));
  assign ev     = cap_ev | cmp_ev;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= chan_pin_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      csc_q   <= '0;
      armed_q <= 1'b0;
    end else begin
      if (csc_wr) begin
        csc_q.channel_irq_enable <= hwdata_in[`TCM_CSC_IE];
        csc_q.mode_select_high   <= hwdata_in[5];
        csc_q.mode_select_low    <= hwdata_in[4];
        csc_q.edge_level_high    <= hwdata_in[3];
        csc_q.edge_level_low     <= hwdata_in[2];
      end
      if (ev) begin
        csc_q.channel_event_flag <= 1'b1;
        armed_q                  <= 1'b0;
      end else if (csc_wr) begin
        if (armed_q && !hwdata_in[`TCM_CSC_FLAG]) begin
          csc_q.channel_event_flag <= 1'b0;
        end
        armed_q <= 1'b0;
      end else if (csc_rd && csc_q.channel_event_flag) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic out_q;
  logic ovf_up;

  assign ovf_up                = step_q & ~center_aligned_pwm_q & (cnt_q == `TCM_RST_WORD);
  assign chan_pin_out          = out_q;
  assign chan_pin_oe_out       = (els != `TCM_EL_OFF) & ~is_cap;
  assign chan_pin_released_out = (els == `TCM_EL_OFF);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_q <= 1'b0;
    end else if (els != `TCM_EL_OFF) begin
      case (mode)
        TCM_MODE_COMPARE: begin
          if (match) begin
            out_q <= (els == `TCM_EL_RISE) ? ~out_q : (els == `TCM_EL_BOTH);
          end
        end
        TCM_MODE_EDGE_ALIGNED_PWM: begin
          // Compare before overflow so a zero value gives 0% duty
          if (match) begin
            out_q <= csc_q.edge_level_low;
          end else if (ovf_up) begin
            out_q <= ~csc_q.edge_level_low;
          end
        end
        TCM_MODE_CENTER_ALIGNED_PWM: begin
          if (match) begin
            out_q <= step_up_q ? csc_q.edge_level_low : ~csc_q.edge_level_low;
          end
        end
        default: begin
          out_q <= out_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel value, write buffer and read latch
  // ----------------------------------------------------------------
  logic [15:0] wbuf_q;
  logic        got_hi_q;
  logic        got_lo_q;
  logic        pend_q;
  logic [15:0] rbuf_q;
  logic        rlat_q;
  logic        rfirst_hi_q;
  logic        buf_wr;
  logic        complete;
  logic [15:0] word;
  logic        load_pend;

  assign buf_wr   = ~halted & ~is_cap & (cvh_wr | cvl_wr);
  assign complete = buf_wr & ((cvh_wr & got_lo_q) | (cvl_wr & got_hi_q));
  assign word     = {cvh_wr ? hwdata_in[7:0] : wbuf_q[15:8], cvl_wr ? hwdata_in[7:0] : wbuf_q[7:0]};
  assign load_pend = pend_q & ((clks_q == `TCM_CLK_NONE)
                     | ((mode == TCM_MODE_COMPARE) & tick)
                     | (is_pwm & tick & ~down_q & (cnt_q == term - `TCM_ONE)));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      val_q <= `TCM_RST_WORD;
    end else if (cap_ev) begin
      val_q <= cnt_q;
    end else if (!is_cap) begin
      if (halted && cvh_wr) begin
        val_q[15:8] <= hwdata_in[7:0];
      end else if (halted && cvl_wr) begin
        val_q[7:0] <= hwdata_in[7:0];
      end else if (complete && clks_q == `TCM_CLK_NONE) begin
        val_q <= word;
      end else if (load_pend) begin
        val_q <= wbuf_q;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wbuf_q   <= `TCM_RST_WORD;
      got_hi_q <= 1'b0;
      got_lo_q <= 1'b0;
      pend_q   <= 1'b0;
    end else if (csc_wr) begin
      got_hi_q <= 1'b0;
      got_lo_q <= 1'b0;
      pend_q   <= 1'b0;
    end else if (buf_wr) begin
      wbuf_q <= word;
      if (complete) begin
        got_hi_q <= 1'b0;
        got_lo_q <= 1'b0;
        pend_q   <= (clks_q != `TCM_CLK_NONE);
      end else begin
        got_hi_q <= got_hi_q | cvh_wr;
        got_lo_q <= got_lo_q | cvl_wr;
      end
    end else if (load_pend) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rbuf_q      <= `TCM_RST_WORD;
      rlat_q      <= 1'b0;
      rfirst_hi_q <= 1'b0;
    end else if (csc_wr) begin
      rlat_q <= 1'b0;
    end else if (!halted && is_cap && (cvh_rd || cvl_rd)) begin
      if (!rlat_q) begin
        rlat_q      <= 1'b1;
        rbuf_q      <= val_q;
        rfirst_hi_q <= cvh_rd;
      end else if (cvh_rd != rfirst_hi_q) begin
        rlat_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] val_view;
  assign val_view = (rlat_q & ~halted & is_cap) ? rbuf_q : val_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_q <= '0;
    end else if (rd_now) begin
      if (dph_q.addr == `TCM_OFS_TSC) begin
        hrdata_q <= {26'h0, center_aligned_pwm_q, clks_q, 3'h0};
      end else if (dph_q.addr == `TCM_OFS_MOD) begin
        hrdata_q <= {16'h0, mod_q};
      end else if (dph_q.addr == `TCM_OFS_CNT) begin
        hrdata_q <= {16'h0, cnt_q};
      end else if (dph_q.addr == `TCM_OFS_CSC) begin
        hrdata_q <= {24'h0, csc_q[7:2], 2'h0};
      end else if (dph_q.addr == `TCM_OFS_CVH) begin
        hrdata_q <= {24'h0, val_view[15:8]};
      end else if (dph_q.addr == `TCM_OFS_CVL) begin
        hrdata_q <= {24'h0, val_view[7:0]};
      end else begin
        hrdata_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_clear_req;
    armed_q && csc_wr && !hwdata_in[`TCM_CSC_FLAG] && !ev;
  endsequence

  sequence s_halt_hold;
    halted && !csc_wr;
  endsequence

  flag_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_clear_req |=> !csc_q.channel_event_flag)
    else $error("flag not cleared by clear sequence");

  flag_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ev |=> csc_q.channel_event_flag)
    else $error("event did not set flag");

  cap_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cap_ev |=> val_q == $past(cnt_q))
    else $error("capture did not load counter value");

  cap_nowrite_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (is_cap && (cvh_wr || cvl_wr) && !cap_ev) |=> $stable(val_q))
    else $error("value changed by write in capture mode");

  ctl_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
    csc_wr |=> !rlat_q && !got_hi_q && !got_lo_q && !pend_q)
    else $error("control write did not reset latches");

  halt_freeze_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_halt_hold |=> $stable(rlat_q) && $stable(got_hi_q) && $stable(got_lo_q))
    else $error("latch state moved during halt");

  halt_direct_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (halted && cvl_wr && !is_cap) |=> val_q[7:0] == $past(hwdata_in[7:0]))
    else $error("halt write missed the register");

  imm_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (complete && clks_q == `TCM_CLK_NONE) |=> val_q == $past(word))
    else $error("second byte did not load value");

  pwm_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (pend_q && is_pwm && clks_q != `TCM_CLK_NONE && !(tick && !down_q && cnt_q == term - `TCM_ONE)
     && !halted) |=> $stable(val_q))
    else $error("PWM value loaded off the modulo step");

  center_turn_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (center_aligned_pwm_q && tick && !cnt_wr && !down_q && cnt_q == term) |=> down_q && cnt_q == $past(term) - `TCM_ONE)
    else $error("center counter did not turn down");

  clk_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (clks_q == `TCM_CLK_NONE && !cnt_wr) |=> $stable(cnt_q))
    else $error("counter moved with no clock");

  oc_toggle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode == TCM_MODE_COMPARE && els == `TCM_EL_RISE && match) |=> out_q != $past(out_q))
    else $error("compare toggle missing");

endmodule
`default_nettype wire

// *** sim/tcm_pin_model.sv ***
// Far-side pin and counter clock source model for the timer channel
`timescale 1ns/1ps
`default_nettype none
module tcm_pin_model (
  // Clock
  input  wire logic clk_in,
  // Block drive of the channel pin
  input  wire logic pin_drv_in,
  input  wire logic pin_oe_in,
  // Pin level and clock sources
  output logic      pin_out,
  output logic      tick_out,
  output logic      ext_clk_out
);
  logic       lvl_q;
  logic [1:0] div_q;
  initial begin
    lvl_q = 1'b0;
    div_q = 2'h0;
  end
  // Wire level: block wins while it drives
  assign pin_out = pin_oe_in ? pin_drv_in : lvl_q;
  assign tick_out = (div_q == 2'h3);
  assign ext_clk_out = div_q[1];
  always @(posedge clk_in) begin
    div_q <= div_q + 2'h1;
  end
  // ---------------------------------------------------------------
  // Edge then settle, so capture never sees a glitch
  // ---------------------------------------------------------------
  task automatic drive(input logic lvl);
    @(posedge clk_in);
    lvl_q <= lvl;
    repeat (3) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** sim/tcm_channel_top_tb.sv ***
// Self-checking bench of the timer channel block
`timescale 1ns/1ps
`default_nettype none
`include "tcm_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tcm_channel_top_tb;
  import tcm_pkg::*;
  logic clk_in, rst_in, hsel, hwrite, halt, pin, tick, ext;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic hready, hresp, pin_drv, pin_oe, pin_rel;
  logic [15:0] c1, c2;
  logic [7:0] v;
  int err_count, n_tests, k;
  tcm_channel_top DUT (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .debug_halt_in(halt), .fixed_tick_in(tick), .ext_clk_in(ext), .chan_pin_in(pin),
    .chan_pin_out(pin_drv), .chan_pin_oe_out(pin_oe), .chan_pin_released_out(pin_rel));
  tcm_pin_model PM (.clk_in(clk_in), .pin_drv_in(pin_drv), .pin_oe_in(pin_oe),
    .pin_out(pin), .tick_out(tick), .ext_clk_out(ext));
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    ahb(1'b0, a, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask
  // Counter counts on the bus clock for n + 2 cycles from the start write, then stops; stopping keeps its value
  task automatic run_cnt(input int n, output logic [15:0] c);
    wr(`TCM_OFS_TSC, 8'h08);
    repeat (n) @(posedge clk_in);
    wr(`TCM_OFS_TSC, 8'h00);
    ahb(1'b0, `TCM_OFS_CNT, 8'h00);
    c = rd[15:0];
  endtask
  task automatic wait_pin(input logic l);
    k = 0;
    while (pin_drv !== l && k < 300) begin
      @(posedge clk_in);
      k++;
    end
    `CHK(pin_drv, l)
  endtask
  function automatic logic [7:0] csc(input logic mh, input logic ml, input logic [1:0] el);
    return {2'b00, mh, ml, el, 2'b00};
  endfunction
  task automatic end_sim();
    $display("mismatches %0d of %0d comparisons", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    #(25 * 60000);
    err_count++;
    end_sim();
  end
  initial begin
    {rst_in, hsel, hwrite, halt, htrans, haddr, hwdata} = '0;
    rst_in = 1'b1;
    err_count = 0;
    n_tests = 0;
    void'($urandom(26623));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    // Reset values and an unmapped place
    rdchk(`TCM_OFS_TSC, 8'h00);
    rdchk(`TCM_OFS_CSC, 8'h00);
    rdchk(`TCM_OFS_CVH, 8'h00);
    rdchk(`TCM_OFS_CVL, 8'h00);
    rdchk(8'h3c, 8'h00);
    `CHK(hresp, 1'b0)
    `CHK(pin_rel, 1'b1)
    // Unclocked compare: second byte loads, control write breaks a pair
    wr(`TCM_OFS_MOD, 8'h40);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b1, 2'h3));
    v = 8'($urandom_range(8'h3f, 8'h01));
    wr(`TCM_OFS_CVH, 8'h00);
    wr(`TCM_OFS_CVL, v);
    rdchk(`TCM_OFS_CVL, v);
    wr(`TCM_OFS_CVH, 8'h12);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b1, 2'h3));
    wr(`TCM_OFS_CVL, 8'h34);
    rdchk(`TCM_OFS_CVH, 8'h00);
    // Halt writes go direct and leave the open pair alone
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b1, 2'h3));
    wr(`TCM_OFS_CVH, 8'h12);
    halt <= 1'b1;
    wr(`TCM_OFS_CVL, 8'h5a);
    rdchk(`TCM_OFS_CVL, 8'h5a);
    rdchk(`TCM_OFS_CVH, 8'h00);
    halt <= 1'b0;
    wr(`TCM_OFS_CVL, v);
    rdchk(`TCM_OFS_CVH, 8'h12);
    wr(`TCM_OFS_CVH, 8'h00);
    wr(`TCM_OFS_CVL, v);
    rdchk(`TCM_OFS_CVH, 8'h00);
    rdchk(`TCM_OFS_CVL, v);
    // Clocked compare: set then clear on match
    `CHK(pin_oe, 1'b1)
    wr(`TCM_OFS_CNT, 8'h00);
    wr(`TCM_OFS_TSC, 8'h08);
    wait_pin(1'b1);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b1, 2'h2));
    wait_pin(1'b0);
    wr(`TCM_OFS_CVH, 8'h00);
    wr(`TCM_OFS_CVL, 8'h21);
    repeat (4) @(posedge clk_in);
    rdchk(`TCM_OFS_CVL, 8'h21);
    // Edge PWM, high-true: both levels within one period
    wr(`TCM_OFS_CSC, csc(1'b1, 1'b0, 2'h2));
    wait_pin(1'b1);
    wait_pin(1'b0);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b1, 2'h0));
    @(posedge clk_in);
    `CHK(pin_rel, 1'b1)
    `CHK(pin_oe, 1'b0)
    // Capture on rising edges with a stopped counter
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b0, 2'h1));
    wr(`TCM_OFS_CVH, 8'hff);
    rdchk(`TCM_OFS_CVH, 8'h00);
    run_cnt(5 + int'($urandom_range(20)), c1);
    PM.drive(1'b1);
    rdchk(`TCM_OFS_CSC, 8'h84);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b0, 2'h1));
    rdchk(`TCM_OFS_CSC, 8'h04);
    rdchk(`TCM_OFS_CVH, c1[15:8]);
    run_cnt(3 + int'($urandom_range(9)), c2);
    PM.drive(1'b0);
    rdchk(`TCM_OFS_CSC, 8'h04);
    PM.drive(1'b1);
    rdchk(`TCM_OFS_CVL, c1[7:0]);
    rdchk(`TCM_OFS_CVL, c2[7:0]);
    // Control write releases an open read latch
    rdchk(`TCM_OFS_CVL, c2[7:0]);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b0, 2'h3));
    run_cnt(4, c1);
    PM.drive(1'b0);
    rdchk(`TCM_OFS_CVL, c1[7:0]);
    // Halt reads show the live value and leave the latch as it was
    run_cnt(5, c2);
    PM.drive(1'b1);
    halt <= 1'b1;
    rdchk(`TCM_OFS_CVH, c2[15:8]);
    rdchk(`TCM_OFS_CVL, c2[7:0]);
    halt <= 1'b0;
    rdchk(`TCM_OFS_CVL, c1[7:0]);
    // Center PWM on the fixed clock: buffered value waits for the modulo step
    wr(`TCM_OFS_TSC, 8'h30);
    wr(`TCM_OFS_CNT, 8'h00);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b0, 2'h2));
    wr(`TCM_OFS_CVH, 8'h01);
    wr(`TCM_OFS_CVL, 8'h20);
    rdchk(`TCM_OFS_CVH, 8'h00);
    repeat (300) @(posedge clk_in);
    rdchk(`TCM_OFS_CVH, 8'h01);
    halt <= 1'b1;
    wr(`TCM_OFS_CVH, 8'h00);
    halt <= 1'b0;
    // Up-count match clears, so the counter is still rising just after it
    wr(`TCM_OFS_TSC, 8'h28);
    wait_pin(1'b1);
    wait_pin(1'b0);
    ahb(1'b0, `TCM_OFS_CNT, 8'h00);
    `CHK(rd[15:0], 16'h0023)
    // Toggle on compare, counter on the external clock
    wr(`TCM_OFS_TSC, 8'h18);
    wr(`TCM_OFS_CSC, csc(1'b0, 1'b1, 2'h1));
    wait_pin(1'b1);
    wait_pin(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
